// ### rtl/enc_channel.sv
// one acquisition channel: quadrature position, speed, acceleration, filter, wiring checks
`timescale 1ns/100ps
`include "enc_plaus_regs.svh"
module enc_channel #(
	parameter int GATE_CYC = `GATE_CYCLES,
	parameter int STUCK_CYC = `STUCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic trk_a,
	input wire logic trk_b,
	input wire logic trk_a_n,
	input wire logic trk_b_n,
	input wire logic [3:0] filt_sel,
	output enc_plaus_pkg::chan_meas_t meas,
	output logic wire_fault
);
	logic [1:0] s1, s2, prev, sn1, sn2;
	logic [31:0] pos, next_pos, filt_pos, next_filt_pos;
	logic [31:0] gate_cnt, next_gate_cnt, per_cnt, next_per_cnt, last_per, next_last_per;
	logic [23:0] steps, next_steps, speed, next_speed, accel, next_accel;
	logic [31:0] stuck_cnt, next_stuck_cnt;
	logic [31:0] filt_cnt, next_filt_cnt;
	logic [31:0] filt_len;
	logic step, dir, bad, next_wire_fault, slow, next_slow;

	// quadrature step decode, also used for illegal-jump check
	function automatic logic [1:0] quad(input logic [1:0] p, input logic [1:0] c);
		logic [3:0] k;
		k = {p, c};
		case (k)
			4'b0001, 4'b0111, 4'b1110, 4'b1000: quad = 2'b01;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: quad = 2'b11;
			4'b0011, 4'b1100, 4'b0110, 4'b1001: quad = 2'b10;
			default: quad = 2'b00;
		endcase
	endfunction

	assign step = quad(prev, s2) == 2'b01 || quad(prev, s2) == 2'b11;
	assign dir = quad(prev, s2) == 2'b11;
	assign filt_len = 32'(filt_sel) * `FILT_STEP_MS * `MS_CYCLES;

	always_comb begin
		next_pos = pos;
		if (step)
			next_pos = dir ? pos - 32'h1 : pos + 32'h1;
		next_gate_cnt = gate_cnt + 32'h1;
		next_steps = step ? steps + 24'h1 : steps;
		next_speed = speed;
		next_accel = accel;
		next_slow = slow;
		next_per_cnt = step ? 32'h0 : per_cnt + 32'h1;
		next_last_per = step ? per_cnt : last_per;
		// fixed gate, never over the maximum; slow path times the step period
		if (gate_cnt >= 32'(GATE_CYC - 1)) begin
			next_gate_cnt = 32'h0;
			next_steps = 24'h0;
			next_slow = last_per > 32'(`FREQ_SWITCH_CYCLES);
			// no step seen yet: all-ones period would divide by zero
			if (next_slow && last_per == 32'hffffffff)
				next_speed = 24'h0;
			else if (next_slow)
				next_speed = 24'((32'(`CLK_HZ) / (last_per + 32'h1)) * 32'(GATE_CYC) / 32'(`CLK_HZ));
			else
				next_speed = steps + 24'(step);
			next_accel = next_speed > speed ? next_speed - speed : speed - next_speed;
		end
		// mean filter approximated by averaging held value with position once per selected time
		next_filt_cnt = filt_cnt + 32'h1;
		next_filt_pos = filt_pos;
		if (filt_cnt >= filt_len) begin
			next_filt_cnt = 32'h0;
			next_filt_pos = (filt_pos >> 1) + (pos >> 1) + 32'(filt_pos[0] & pos[0]);
		end
		// complementary pair equal = short or open; no edges for a long time at nonzero speed = stuck
		bad = (s2[0] == sn2[0]) || (s2[1] == sn2[1]) || quad(prev, s2) == 2'b10;
		next_stuck_cnt = (s2 != prev) ? 32'h0 : stuck_cnt + 32'h1;
		next_wire_fault = bad || (stuck_cnt >= 32'(STUCK_CYC) && speed != 24'h0);
		if (stuck_cnt >= 32'(STUCK_CYC))
			next_stuck_cnt = stuck_cnt;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= 2'h0; s2 <= 2'h0; prev <= 2'h0; sn1 <= 2'h3; sn2 <= 2'h3;
			pos <= 32'h0; filt_pos <= 32'h0; gate_cnt <= 32'h0; per_cnt <= 32'h0;
			last_per <= 32'hffffffff; steps <= 24'h0; speed <= 24'h0; accel <= 24'h0;
			stuck_cnt <= 32'h0; filt_cnt <= 32'h0; wire_fault <= 1'b0; slow <= 1'b1;
		end else begin
			s1 <= {trk_b, trk_a}; s2 <= s1; prev <= s2;
			sn1 <= {trk_b_n, trk_a_n}; sn2 <= sn1;
			pos <= next_pos; filt_pos <= next_filt_pos; gate_cnt <= next_gate_cnt;
			per_cnt <= next_per_cnt; last_per <= next_last_per; steps <= next_steps;
			speed <= next_speed; accel <= next_accel; stuck_cnt <= next_stuck_cnt;
			filt_cnt <= next_filt_cnt; wire_fault <= next_wire_fault; slow <= next_slow;
		end
	end

	always_comb begin
		meas.pos = (filt_sel == 4'h0) ? pos : filt_pos;
		meas.speed = speed;
		meas.accel = accel;
		meas.speed_slow = slow;
	end

	a_gate_bound: assert property (@(posedge clk) disable iff (rst)
		gate_cnt < 32'(GATE_CYC)) else $error("gate longer than maximum");
	a_pair_short: assert property (@(posedge clk) disable iff (rst)
		(s2[0] == sn2[0] || s2[1] == sn2[1]) |=> wire_fault) else $error("complementary pair fault lost");
endmodule // enc_channel

// ### rtl/enc_plaus.sv
// dual-channel position/speed plausibility monitor with crosswise output readback
`timescale 1ns/100ps
`include "enc_plaus_regs.svh"
module enc_plaus #(
	parameter int GATE_CYC = `GATE_CYCLES,
	parameter int STUCK_CYC = `STUCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] enc_a,
	input wire logic [3:0] enc_b,
	input wire logic [31:0] pos_limit,
	input wire logic [23:0] speed_limit,
	input wire logic [3:0] filt_sel,
	input wire logic out_req_a,
	input wire logic out_req_b,
	input wire logic readback_a,
	input wire logic readback_b,
	input wire logic fault_clear,
	output logic dual_processed_safe_output_a,
	output logic dual_processed_safe_output_b,
	output logic fault,
	output logic shutdown_req,
	output enc_plaus_pkg::fault_t fault_cause,
	output logic [31:0] pos_a,
	output logic [23:0] speed_a
);
	enc_plaus_pkg::chan_meas_t ma, mb;
	enc_plaus_pkg::fault_t now, next_fault_cause;
	enc_plaus_pkg::mon_state_t state, next_state;
	logic wf_a, wf_b;
	logic [3:0] fsel;
	logic [1:0] rb1, rb2;
	logic [31:0] pdiff;
	logic [23:0] sdiff;
	logic next_out_a, next_out_b;
	// outputs delayed to match the readback synchroniser
	logic [1:0] out_d1, out_d2;

	assign fsel = (filt_sel > 4'(`FILT_MAX_SEL)) ? 4'(`FILT_MAX_SEL) : filt_sel;

	enc_channel #(.GATE_CYC(GATE_CYC), .STUCK_CYC(STUCK_CYC)) u_a (
		.clk(clk), .rst(rst), .trk_a(enc_a[0]), .trk_b(enc_a[1]), .trk_a_n(enc_a[2]),
		.trk_b_n(enc_a[3]), .filt_sel(fsel), .meas(ma), .wire_fault(wf_a));
	enc_channel #(.GATE_CYC(GATE_CYC), .STUCK_CYC(STUCK_CYC)) u_b (
		.clk(clk), .rst(rst), .trk_a(enc_b[0]), .trk_b(enc_b[1]), .trk_a_n(enc_b[2]),
		.trk_b_n(enc_b[3]), .filt_sel(fsel), .meas(mb), .wire_fault(wf_b));

	always_comb begin
		pdiff = (ma.pos > mb.pos) ? ma.pos - mb.pos : mb.pos - ma.pos;
		sdiff = (ma.speed > mb.speed) ? ma.speed - mb.speed : mb.speed - ma.speed;
		now.pos_dev = pdiff > pos_limit;
		now.speed_dev = sdiff > speed_limit;
		now.wire_a = wf_a;
		now.wire_b = wf_b;
		// channel A output checked by channel B readback and the other way round
		now.readback = rb2 != out_d2;
	end

	always_comb begin
		next_state = state;
		next_fault_cause = fault_cause | now; // set wins over clear
		case (state)
			enc_plaus_pkg::RUN: if (now != '0) next_state = enc_plaus_pkg::TRIP;
			enc_plaus_pkg::TRIP: if (fault_clear && now == '0) begin
				next_state = enc_plaus_pkg::RUN;
				next_fault_cause = '0;
			end
			default: next_state = enc_plaus_pkg::TRIP;
		endcase
		next_out_a = out_req_a && next_state == enc_plaus_pkg::RUN;
		next_out_b = out_req_b && next_state == enc_plaus_pkg::RUN;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= enc_plaus_pkg::TRIP;
			fault_cause <= '0;
			rb1 <= 2'h0;
			rb2 <= 2'h0;
			out_d1 <= 2'h0;
			out_d2 <= 2'h0;
			dual_processed_safe_output_a <= 1'b0;
			dual_processed_safe_output_b <= 1'b0;
		end else begin
			state <= next_state;
			fault_cause <= next_fault_cause;
			rb1 <= {readback_b, readback_a};
			rb2 <= rb1;
			out_d1 <= {dual_processed_safe_output_a, dual_processed_safe_output_b};
			out_d2 <= out_d1;
			dual_processed_safe_output_a <= next_out_a;
			dual_processed_safe_output_b <= next_out_b;
		end
	end

	assign fault = state == enc_plaus_pkg::TRIP;
	assign shutdown_req = fault;
	assign pos_a = ma.pos;
	assign speed_a = ma.speed;

	a_shutdown_on_dev: assert property (@(posedge clk) disable iff (rst)
		(state == enc_plaus_pkg::RUN && now.pos_dev) |=> fault) else $error("position deviation not tripped");
	a_speed_dev_trip: assert property (@(posedge clk) disable iff (rst)
		(state == enc_plaus_pkg::RUN && now.speed_dev) |=> shutdown_req) else $error("speed deviation not tripped");
	a_wire_trip: assert property (@(posedge clk) disable iff (rst)
		(wf_a || wf_b) |=> fault_cause.wire_a || fault_cause.wire_b) else $error("wire fault lost");
	a_out_off_trip: assert property (@(posedge clk) disable iff (rst)
		fault |-> !dual_processed_safe_output_a && !dual_processed_safe_output_b) else $error("output on while tripped");
	a_readback_mis: assert property (@(posedge clk) disable iff (rst)
		now.readback |=> fault) else $error("readback mismatch not tripped");
	a_filter_range: assert property (@(posedge clk) disable iff (rst)
		fsel <= 4'(`FILT_MAX_SEL)) else $error("filter time over range");
	a_cause_sticky: assert property (@(posedge clk) disable iff (rst)
		(fault_cause.pos_dev && !fault_clear) |=> fault_cause.pos_dev) else $error("cause dropped");
	a_stay_tripped: assert property (@(posedge clk) disable iff (rst)
		(fault && !fault_clear) [*2] |=> fault) else $error("left trip without clear");

	// trip entry and trip release as separate steps
	sequence s_live_cause_run;
		state == enc_plaus_pkg::RUN && now != '0;
	endsequence
	sequence s_clear_granted;
		state == enc_plaus_pkg::TRIP && fault_clear && now == '0;
	endsequence
	sequence s_quiet_run;
		state == enc_plaus_pkg::RUN && now == '0;
	endsequence
	a_cause_trips: assert property (@(posedge clk) disable iff (rst)
		s_live_cause_run |=> fault && shutdown_req) else $error("live cause did not trip");
	a_clear_release: assert property (@(posedge clk) disable iff (rst)
		s_clear_granted |=> !fault && fault_cause == '0) else $error("clear did not release trip");
	a_out_follow: assert property (@(posedge clk) disable iff (rst)
		s_quiet_run |=> dual_processed_safe_output_a == $past(out_req_a)
		&& dual_processed_safe_output_b == $past(out_req_b)) else $error("output not following request");
	a_speed_cause: assert property (@(posedge clk) disable iff (rst)
		now.speed_dev |=> fault_cause.speed_dev) else $error("speed cause lost");
	a_readback_cause: assert property (@(posedge clk) disable iff (rst)
		now.readback |=> fault_cause.readback) else $error("readback cause lost");
	a_wire_b_cause: assert property (@(posedge clk) disable iff (rst)
		wf_b |=> fault_cause.wire_b) else $error("channel b wire cause lost");
	a_wire_a_cause: assert property (@(posedge clk) disable iff (rst)
		wf_a |=> fault_cause.wire_a) else $error("channel a wire cause lost");
endmodule // enc_plaus

// ### rtl/enc_plaus_pkg.sv
// types for the dual-channel encoder plausibility monitor
package enc_plaus_pkg;
	typedef struct packed {
		logic [31:0] pos;
		logic [23:0] speed;
		logic [23:0] accel;
		logic speed_slow;
	} chan_meas_t;
	typedef struct packed {
		logic pos_dev;
		logic speed_dev;
		logic wire_a;
		logic wire_b;
		logic readback;
	} fault_t;
	typedef enum logic [1:0] {
		RUN = 2'b00,
		TRIP = 2'b01
	} mon_state_t;
endpackage

// ### rtl/enc_plaus_regs.svh
// constants for the dual-channel encoder plausibility monitor
`ifndef ENC_PLAUS_REGS_SVH
`define ENC_PLAUS_REGS_SVH
`define CLK_HZ 10000000
`define FREQ_SWITCH_HZ 500
`define GATE_MAX_MS 256
`define GATE_CYCLES ((`CLK_HZ / 1000) * `GATE_MAX_MS)
`define FREQ_SWITCH_CYCLES (`CLK_HZ / `FREQ_SWITCH_HZ)
`define FILT_STEP_MS 8
`define FILT_MAX_SEL 8
`define MS_CYCLES (`CLK_HZ / 1000)
`define STUCK_MS 256
`define STUCK_CYCLES ((`CLK_HZ / 1000) * `STUCK_MS)
`endif

// ### verif/dual_channel_encoder_plausibility_test.sv
// self-checking bench for the dual-channel encoder plausibility monitor
`timescale 1ns/100ps
module dual_channel_encoder_plausibility_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic run_a = 1'b0;
	logic run_b = 1'b0;
	logic short_a = 1'b0;
	logic short_b = 1'b0;
	logic [23:0] speed_limit = 24'hffffff;
	logic [3:0] filt_sel = 4'h0;
	logic [31:0] pos_a;
	logic [23:0] speed_a;
	logic rb_break = 1'b0;
	logic out_req_a = 1'b0;
	logic out_req_b = 1'b0;
	logic fault_clear = 1'b0;
	logic [3:0] enc_a;
	logic [3:0] enc_b;
	logic out_a;
	logic out_b;
	logic fault;
	logic shutdown_req;
	enc_plaus_pkg::fault_t cause;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	enc_model i_enc_a (.clk(clk), .run(run_a), .short_fault(short_a), .enc(enc_a));
	enc_model i_enc_b (.clk(clk), .run(run_b), .short_fault(short_b), .enc(enc_b));
	enc_plaus #(.GATE_CYC(64), .STUCK_CYC(256)) i_dut (.clk(clk), .rst(rst), .enc_a(enc_a), .enc_b(enc_b),
		.pos_limit(32'h4), .speed_limit(speed_limit), .filt_sel(filt_sel), .out_req_a(out_req_a),
		.out_req_b(out_req_b), .readback_a(out_b), .readback_b(out_a ^ rb_break),
		.fault_clear(fault_clear), .dual_processed_safe_output_a(out_a),
		.dual_processed_safe_output_b(out_b), .fault(fault), .shutdown_req(shutdown_req),
		.fault_cause(cause), .pos_a(pos_a), .speed_a(speed_a));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic check_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_fault(input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim && fault !== lvl; i++) begin
			wait_cycles(1);
		end
	endtask
	task automatic clear_trip;
		@(posedge clk);
		fault_clear <= 1'b1;
		wait_fault(1'b0, 20);
		@(posedge clk);
		fault_clear <= 1'b0;
		check_bit("fault after clear", 1'b0, fault);
	endtask
	task automatic t_reset;
		wait_cycles(2);
		check_bit("fault in reset", 1'b1, fault);
		check_bit("out a in reset", 1'b0, out_a);
		@(posedge clk);
		rst <= 1'b0;
		wait_cycles(3);
		check_bit("shutdown after reset", 1'b1, shutdown_req);
		check_val("position a after reset", 32'h0, pos_a);
		clear_trip();
	endtask
	task automatic t_follow;
		@(posedge clk);
		out_req_a <= 1'b1;
		out_req_b <= 1'b1;
		wait_cycles(2);
		check_bit("out a follows", 1'b1, out_a);
		check_bit("out b follows", 1'b1, out_b);
		wait_cycles(10);
		check_bit("no fault on good readback", 1'b0, fault);
	endtask
	task automatic t_readback;
		@(posedge clk);
		rb_break <= 1'b1;
		wait_fault(1'b1, 8);
		check_bit("readback trip", 1'b1, cause.readback);
		wait_cycles(1);
		check_bit("out a off in trip", 1'b0, out_a);
		check_bit("shutdown on readback", 1'b1, shutdown_req);
		@(posedge clk);
		rb_break <= 1'b0;
		wait_cycles(5);
		check_bit("request refused in trip", 1'b0, out_b);
		out_req_a <= 1'b0;
		out_req_b <= 1'b0;
		clear_trip();
	endtask
	task automatic t_short;
		@(posedge clk);
		short_a <= 1'b1;
		short_b <= 1'b1;
		wait_fault(1'b1, 20);
		check_bit("short on channel a", 1'b1, cause.wire_a);
		check_bit("short on channel b", 1'b1, cause.wire_b);
		@(posedge clk);
		short_a <= 1'b0;
		short_b <= 1'b0;
		clear_trip();
		check_bit("short cause cleared", 1'b0, cause.wire_a);
	endtask
	task automatic t_both;
		@(posedge clk);
		run_a <= 1'b1;
		run_b <= 1'b1;
		wait_cycles(200);
		check_bit("tracking channels agree", 1'b0, fault);
		check_val("speed a per gate", 32'h8, 32'(speed_a));
		@(posedge clk);
		run_a <= 1'b0;
		run_b <= 1'b0;
	endtask
	task automatic t_pos_dev;
		@(posedge clk);
		filt_sel <= 4'hf;
		run_b <= 1'b1;
		wait_cycles(100);
		check_bit("filter holds deviation back", 1'b0, fault);
		@(posedge clk);
		filt_sel <= 4'h0;
		wait_fault(1'b1, 40);
		check_bit("position deviation", 1'b1, cause.pos_dev);
		check_bit("wire b quiet", 1'b0, cause.wire_b);
		@(posedge clk);
		speed_limit <= 24'h4;
		wait_cycles(150);
		check_bit("speed deviation", 1'b1, cause.speed_dev);
		@(posedge clk);
		run_b <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		t_reset();
		t_follow();
		t_readback();
		t_short();
		t_both();
		t_pos_dev();
		give_verdict();
	end
endmodule // dual_channel_encoder_plausibility_test

// ### verif/enc_model.sv
// quadrature encoder stand-in with wiring fault injection
`timescale 1ns/100ps
module enc_model (
	input wire logic clk,
	input wire logic run,
	input wire logic short_fault,
	output logic [3:0] enc
);
	logic [1:0] ph = 2'h0;
	logic [2:0] div = 3'h0;
	// one quadrature step every eight clocks while running
	always_ff @(posedge clk) begin
		div <= div + 3'h1;
		if (run && div == 3'h7) begin
			ph <= ph + 2'h1;
		end
	end
	// complement lines mirror the tracks unless shorted to track a
	always_comb begin
		enc[0] = ph[1] ^ ph[0];
		enc[1] = ph[1];
		enc[2] = short_fault ? (ph[1] ^ ph[0]) : ~(ph[1] ^ ph[0]);
		enc[3] = ~ph[1];
	end
endmodule // enc_model
